// ==== pkg/mis_pkg.sv ====
// constants and carriers for the memory interleave steering block
package mis_pkg;
    localparam int ADDR_W      = 35;
    localparam int SEC_LSB     = 0;
    localparam int SUB_LSB     = 3;
    localparam int BANK_LSB    = 6;
    localparam int WORD_LSB    = 10;
    localparam int WORD_W      = 24;
    localparam int RSV_SMALL_LO = 27;
    localparam int RSV_SMALL_HI = 31;
    localparam int RSV_MID_LO   = 29;
    localparam int RSV_MID_HI   = 33;
    localparam int RSV_LARGE_LO = 30;
    localparam int RSV_LARGE_HI = 34;
    localparam int SECTIONS     = 8;
    localparam int SUBS         = 8;
    localparam int BANKS_MID    = 8;
    localparam int BANKS_LARGE  = 16;
    localparam int TOTAL_MID    = 512;
    localparam int TOTAL_LARGE  = 1024;
    localparam int SPARES       = 2;
    localparam int CHIPS_HALF   = 20;
    localparam int CHIP_W       = 5;

    typedef enum logic [1:0] {
        MIS_SMALL,
        MIS_MIDDLE,
        MIS_LARGE
    } mis_size_e;

    typedef struct packed {
        mis_size_e  size;
        logic [2:0] modules_log2;
    } mis_cfg_s;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
    } mis_req_s;

    typedef struct packed {
        logic        valid;
        logic [1:0]  stack;
        logic [2:0]  module_idx;
        logic [2:0]  section;
        logic [2:0]  subsection;
        logic [3:0]  bank;
        logic [WORD_W-1:0] word;
    } mis_route_s;

    typedef struct packed {
        logic              enable;
        logic [CHIP_W-1:0] chip;
    } mis_flaw_s;
endpackage

// ==== logic/mis_spare_map.sv ====
// half-stack spare chip bypass: maps logical chip to physical chip
`timescale 1ns/1ps
module mis_spare_map
(
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       ce,
    input  wire mis_pkg::mis_flaw_s         flaw,
    input  wire logic [mis_pkg::CHIP_W-1:0] logical_chip,
    output logic [mis_pkg::CHIP_W-1:0]      physical_chip,
    output logic                            on_spare
);
    import mis_pkg::*;

    logic [CHIP_W-1:0] phys_next;
    logic              spare_next;

    // chips at or past the flaw move one step toward the spare
    always_comb
    begin
        phys_next  = logical_chip;
        spare_next = 1'b0;
        if (flaw.enable && logical_chip >= flaw.chip)
        begin
            if (logical_chip == CHIP_W'(CHIPS_HALF - 2))
                spare_next = 1'b1;
            else
                phys_next = logical_chip + CHIP_W'(1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            physical_chip <= '0;
            on_spare      <= 1'b0;
        end
        else if (ce)
        begin
            physical_chip <= phys_next;
            on_spare      <= spare_next;
        end
    end
endmodule

// ==== logic/mis_steer.sv ====
// address steering for sequential references over sections, subsections, banks
`timescale 1ns/1ps
module mis_steer
(
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         ce,
    input  wire mis_pkg::mis_cfg_s            cfg,
    input  wire mis_pkg::mis_req_s            req,
    input  wire mis_pkg::mis_flaw_s           flaw_lower,
    input  wire mis_pkg::mis_flaw_s           flaw_upper,
    input  wire logic [mis_pkg::CHIP_W-1:0]   chip_sel,
    output mis_pkg::mis_route_s               route,
    output logic                              reserved_nonzero,
    output logic [mis_pkg::CHIP_W-1:0]        lower_phys_chip,
    output logic                              lower_on_spare,
    output logic [mis_pkg::CHIP_W-1:0]        upper_phys_chip,
    output logic                              upper_on_spare
);
    import mis_pkg::*;

    mis_route_s        route_next;
    logic              rsv_next;
    logic [2:0]        sec;
    logic [2:0]        sub;
    logic [3:0]        bnk;
    logic [2:0]        mod_mask;

    // reserved field of the address for a given size
    function automatic logic [ADDR_W-1:0] reserved_mask(input mis_size_e sz);
        logic [ADDR_W-1:0] m;
        m = '0;
        for (int i = 0; i < ADDR_W; i++)
        begin
            case (sz)
                MIS_SMALL:  m[i] = (i >= RSV_SMALL_LO) && (i <= RSV_SMALL_HI);
                MIS_MIDDLE: m[i] = (i >= RSV_MID_LO) && (i <= RSV_MID_HI);
                MIS_LARGE:  m[i] = (i >= RSV_LARGE_LO) && (i <= RSV_LARGE_HI);
                default:    m[i] = 1'b0;
            endcase
        end
        return m;
    endfunction

    // bits of the address that form the word index, starting above the bank field
    function automatic logic [WORD_W-1:0] word_field(input logic [ADDR_W-1:0] a,
                                                     input mis_size_e sz,
                                                     input int lsb);
        logic [WORD_W-1:0] w;
        logic [ADDR_W-1:0] keep;
        // reserved bits cleared before the cut, so they never leak into the word
        keep = a & ~reserved_mask(sz);
        w    = keep[lsb +: WORD_W];
        return w;
    endfunction

    assign sec      = req.addr[SEC_LSB +: 3];
    assign sub      = req.addr[SUB_LSB +: 3];
    assign bnk      = req.addr[BANK_LSB +: 4];
    assign mod_mask = 3'((1 << cfg.modules_log2) - 1);

    always_comb
    begin
        route_next       = '0;
        route_next.valid = req.valid;
        route_next.section = sec;
        rsv_next = |(req.addr & reserved_mask(cfg.size));
        route_next.word = word_field(req.addr, cfg.size, WORD_LSB);
        case (cfg.size)
            MIS_SMALL:
            begin
                // one stack, two whole sections per module, no subsections
                route_next.stack      = 2'd0;
                route_next.module_idx = {1'b0, sec[2:1]} & mod_mask;
                route_next.subsection = 3'd0;
                // address bits above the section field count banks
                route_next.bank = req.addr[SUB_LSB +: 4];
                route_next.word = word_field(req.addr, cfg.size, SUB_LSB + 4);
                // with two modules only four sections exist, so banks start one bit lower
                if (cfg.modules_log2 == 3'd1)
                begin
                    route_next.section = {1'b0, sec[1:0]};
                    route_next.bank    = req.addr[SUB_LSB - 1 +: 4];
                    route_next.word    = word_field(req.addr, cfg.size, SUB_LSB + 3);
                end
            end
            MIS_MIDDLE:
            begin
                // sections 2..5 live in the second stack
                route_next.stack = (sec >= 3'd2 && sec <= 3'd5) ? 2'd1 : 2'd0;
                route_next.subsection = sub;
                route_next.module_idx = sub & mod_mask;
                route_next.bank = {1'b0, bnk[2:0]};
                route_next.word = word_field(req.addr, cfg.size, BANK_LSB + 3);
            end
            MIS_LARGE:
            begin
                // pairs of sections spiral over four stacks
                route_next.stack      = sec[2:1];
                route_next.subsection = sub;
                // descending module order as subsection advances
                route_next.module_idx = (~sub) & mod_mask;
                route_next.bank       = bnk;
            end
            default:
            begin
                route_next.valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            route            <= '0;
            reserved_nonzero <= 1'b0;
        end
        else if (ce)
        begin
            route            <= route_next;
            reserved_nonzero <= rsv_next & req.valid;
        end
    end

    // one spare per half-stack; both halves use the same bypass logic, each with its own flaw input
    mis_spare_map u_lower
    (
        .clk           (clk),
        .rst           (rst),
        .ce            (ce),
        .flaw          (flaw_lower),
        .logical_chip  (chip_sel),
        .physical_chip (lower_phys_chip),
        .on_spare      (lower_on_spare)
    );

    mis_spare_map u_upper
    (
        .clk           (clk),
        .rst           (rst),
        .ce            (ce),
        .flaw          (flaw_upper),
        .logical_chip  (chip_sel),
        .physical_chip (upper_phys_chip),
        .on_spare      (upper_on_spare)
    );
    // correction lives in the processor; data passes untouched
endmodule

// ==== bench/mis_steer_checker.sv ====
// assertion checker for the steering outputs
`timescale 1ns/1ps
module mis_steer_checker
(
    input wire logic                clk,
    input wire logic                rst,
    input wire logic                ce,
    input wire mis_pkg::mis_cfg_s   cfg,
    input wire mis_pkg::mis_req_s   req,
    input wire mis_pkg::mis_route_s route,
    input wire logic                reserved_nonzero
);
    import mis_pkg::*;
    logic vs;
    logic vm;
    logic vl;
    assign vs = ce && req.valid && cfg.size == MIS_SMALL;
    assign vm = ce && req.valid && cfg.size == MIS_MIDDLE;
    assign vl = ce && req.valid && cfg.size == MIS_LARGE;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_rs; vs |=> reserved_nonzero == $past(|req.addr[31:27]); endproperty
    a_rs: assert property (p_rs) else $error("small reserved flag");
    property p_rm; vm |=> reserved_nonzero == $past(|req.addr[33:29]); endproperty
    a_rm: assert property (p_rm) else $error("middle reserved flag");
    property p_rl; vl |=> reserved_nonzero == $past(|req.addr[34:30]); endproperty
    a_rl: assert property (p_rl) else $error("large reserved flag");
    property p_ss; vs |=> route.subsection == 3'h0 && route.stack == 2'h0; endproperty
    a_ss: assert property (p_ss) else $error("small subsection");
    property p_sm; vm |=> route.stack == {1'b0, $past(^req.addr[2:1])}; endproperty
    a_sm: assert property (p_sm) else $error("middle stack");
    property p_bm; vm |=> route.subsection == $past(req.addr[5:3]); endproperty
    a_bm: assert property (p_bm) else $error("middle subsection");
    property p_sl; vl |=> route.stack == $past(req.addr[2:1]); endproperty
    a_sl: assert property (p_sl) else $error("large stack");
    property p_bl; vl |=> route.bank == $past(req.addr[9:6]); endproperty
    a_bl: assert property (p_bl) else $error("large bank");
endmodule

bind mis_steer mis_steer_checker u_chk (.clk, .rst, .ce, .cfg, .req, .route, .reserved_nonzero);

// ==== bench/mis_proc_model.sv ====
// processor-side model issuing sequential references
`timescale 1ns/1ps
module mis_proc_model
(
    input  wire logic                       clk,
    input  wire logic                       load,
    input  wire logic [mis_pkg::ADDR_W-1:0] base,
    input  wire logic                       en,
    output mis_pkg::mis_req_s               req
);
    import mis_pkg::*;
    // correction stays on this side; the steering path never sees check bits
    logic [ADDR_W-1:0] next_reg;
    always_ff @(posedge clk)
        if (load)
            next_reg <= base;
        else if (en)
            next_reg <= next_reg + 1'b1;
    // idle address inverted so a stale value never looks live
    assign req = '{en, en ? next_reg : ~next_reg};
endmodule

// ==== bench/tb.sv ====
// self-checking bench for the steering block
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %0t value mismatch", $time); end end
module tb;
    import mis_pkg::*;
    logic clk = 0, rst = 1, ld = 0, en = 0, rsv, lo_s, hi_s;
    logic [ADDR_W-1:0] base = '0;
    logic [CHIP_W-1:0] chip_sel = '0, lo_p, hi_p;
    logic [39:0] got, q[$];
    mis_cfg_s cfg = '0;
    mis_flaw_s flo = '0, fhi = '0;
    mis_req_s req;
    mis_route_s route;
    int bad_count = 0, cmp_count = 0, seed = 9605;
    always #5 clk = ~clk;
    mis_proc_model pm (.clk(clk), .load(ld), .base(base), .en(en), .req(req));
    mis_steer uut (.clk(clk), .rst(rst), .ce(1'b1), .cfg(cfg), .req(req), .flaw_lower(flo),
        .flaw_upper(fhi), .chip_sel(chip_sel), .route(route), .reserved_nonzero(rsv),
        .lower_phys_chip(lo_p), .lower_on_spare(lo_s), .upper_phys_chip(hi_p),
        .upper_on_spare(hi_s));
    function automatic logic [39:0] exp_of(logic [ADDR_W-1:0] a);
        logic [2:0] m;
        logic [ADDR_W-1:0] k;
        m = 3'((4'h1 << cfg.modules_log2) - 4'h1);
        k = a;
        case (cfg.size)
            MIS_SMALL:
            begin
                k[31:27] = '0;
                if (cfg.modules_log2 == 3'h1)
                    return {1'b0, a[1:0], k[6 +: 24], 2'h0, {1'b0, a[2:1]} & m, 3'h0, a[5:2],
                        |a[31:27]};
                return {a[2:0], k[7 +: 24], 2'h0, {1'b0, a[2:1]} & m, 3'h0, a[6:3],
                    |a[31:27]};
            end
            MIS_MIDDLE:
            begin
                k[33:29] = '0;
                return {a[2:0], k[9 +: 24], 1'b0, ^a[2:1], a[5:3] & m, a[5:3], 1'b0, a[8:6],
                    |a[33:29]};
            end
            default:
            begin
                k[34:30] = '0;
                return {a[2:0], k[10 +: 24], a[2:1], ~a[5:3] & m, a[5:3], a[9:6],
                    |a[34:30]};
            end
        endcase
    endfunction
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic burst(int n);
        logic [ADDR_W-1:0] a;
        a = ADDR_W'({$random(seed), $random(seed)});
        a[9:0] = '0;
        if ($random(seed) & 1)
            a[34:27] = '0;
        base = a;
        ld = 1;
        @(posedge clk);
        #1 ld = 0;
        while (n > 0)
        begin
            en = ($random(seed) & 3) != 0;
            if (en)
            begin
                q.push_back(exp_of(a));
                a++;
                n--;
            end
            @(posedge clk);
            #1;
        end
        en = 0;
        for (int i = 0; i < 8 && q.size() > 0; i++)
            @(posedge clk);
        #1;
        if (q.size() != 0)
        begin
            bad_count++;
            report_and_stop();
        end
    endtask
    task automatic spare_pass(logic e);
        flo = '{e, 5'h05};
        fhi = '{e, 5'h09};
        for (int c = 0; c < 19; c++)
        begin
            chip_sel = c[4:0];
            @(posedge clk);
            #1;
            `CHK({lo_s, hi_s}, {2{e && c == 18}})
            if (c < 18)
                `CHK({lo_p, hi_p}, {5'(c + (e && c >= 5)), 5'(c + (e && c >= 9))})
        end
        $display("spare test done, flaw enable %0d", e);
    endtask
    always @(posedge clk)
    begin
        #1;
        got = {route.section, route.word, route.stack, route.module_idx, route.subsection,
            route.bank, rsv};
        if (route.valid === 1'b1 && q.size() == 0)
            `CHK(1'b1, 1'b0)
        else if (route.valid === 1'b1)
            `CHK(got, q.pop_front())
    end
    initial
    begin
        repeat (10) @(posedge clk);
        #1 rst = 0;
        for (int s = 0; s < 3; s++)
            for (int m = 1; m < 3; m++)
            begin
                cfg = '{mis_size_e'(s), 3'(m)};
                burst(40);
                $display("steer test size %0d modules_log2 %0d done", s, m);
            end
        spare_pass(1'b0);
        spare_pass(1'b1);
        report_and_stop();
    end
endmodule
